// ### attn_regs.svh
// Constants for the attenuator step control block
`ifndef ATTN_REGS_SVH
`define ATTN_REGS_SVH

// ----------------------------------------------------------------
// Word layout
// ----------------------------------------------------------------
`define ATTN_WORD_W        6
`define ATTN_WORD_MSB      5
`define ATTN_SYNC_STAGES   3

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ATTN_CLK_MHZ       125
`define ATTN_POWERUP_MS    200
`define ATTN_POWERUP_CYC   (`ATTN_POWERUP_MS * 1000 * `ATTN_CLK_MHZ)

// ----------------------------------------------------------------
// Power-up words (active-low control bits)
// ----------------------------------------------------------------
`define ATTN_PUP_MAX       6'h00
`define ATTN_PUP_24DB      6'h0F
`define ATTN_PUP_16DB      6'h1F
`define ATTN_PUP_MIN       6'h3F
`define ATTN_RESET_WORD    6'h3F

// ----------------------------------------------------------------
// Counter
// ----------------------------------------------------------------
`define ATTN_CNT_W         32
`define ATTN_CNT_ZERO      32'h0000_0000
`define ATTN_CNT_ONE       32'h0000_0001

`endif

// ### attn_pkg.sv
// Types shared by the attenuator step control block
package attn_pkg;

	// ------------------------------------------------------------
	// Pin group sampled from outside the clock domain
	// ------------------------------------------------------------
	typedef struct packed {
		logic       serial_clk;
		logic       serial_data_in;
		logic       load_strobe;
		logic       interface_select;
		logic       powerup_select_a;
		logic       powerup_select_b;
		logic [5:0] parallel_control_word;
	} attn_pins_t;

	// ------------------------------------------------------------
	// Control states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		ATTN_ST_WAIT = 2'b00,
		ATTN_ST_RUN  = 2'b01
	} attn_state_t;

endpackage

// ### attn_step_control.sv
// Attenuator step control: serial, direct and latched parallel loading
//
// Contract
// - Serial programming only while interface select high
// - Act on rising serial clock edges; strobe acts on its high level, not its edge
// - Strobe high in serial mode loads shift register
// - Serial clock ignored while strobe high
// - Select low: serial ignored, parallel word loads
// - Attenuation state held while strobe low after power-up
// - Strobe low at power-up: select pins choose state
// - Strobe high at power-up: parallel word used
// - Power-up state latched 200 ms after start
// - Active-low bits, binary half-dB weights summed
// - Serial output is input delayed six serial clock rising edges
`timescale 1ns/1ps
`default_nettype none
`include "attn_regs.svh"

module attn_step_control #(
	parameter int POWERUP_CYCLES = `ATTN_POWERUP_CYC
) (
	input  wire logic                     clk,               // System clock
	input  wire logic                     rstn,              // Sync reset, low
	input  wire logic                     ce,                // Clock enable
	input  wire attn_pkg::attn_pins_t     pins,              // Raw control pins
	output logic [`ATTN_WORD_MSB:0]       atten_word,        // Active-low bits
	output logic [`ATTN_WORD_MSB:0]       atten_half_db,     // Loss in 0.5 dB
	output logic                          serial_data_out,   // Cascade output
	output logic                          powerup_done       // Start-up latched
);
	import attn_pkg::*;

	// Refused at elaboration: a zero count would wrap the counter and stretch the wait
	if (POWERUP_CYCLES < 1)
	begin : g_bad_powerup
		$error("POWERUP_CYCLES must be at least one");
	end

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	// Three stages; a change is accepted only once stages two and
	// three agree, which also rejects single-sample glitches.
	attn_pins_t sync1_ff;
	attn_pins_t sync2_ff;
	attn_pins_t sync3_ff;
	attn_pins_t filt_ff;
	attn_pins_t nxt_sync1;
	attn_pins_t nxt_sync2;
	attn_pins_t nxt_sync3;
	attn_pins_t nxt_filt;

	always_comb
	begin
		nxt_sync1 = sync1_ff;
		nxt_sync2 = sync2_ff;
		nxt_sync3 = sync3_ff;
		nxt_filt  = filt_ff;
		if (ce)
		begin
			nxt_sync1 = pins;
			nxt_sync2 = sync1_ff;
			nxt_sync3 = sync2_ff;
			nxt_filt  = (sync2_ff & ~(sync2_ff ^ sync3_ff))
			          | (filt_ff & (sync2_ff ^ sync3_ff));
		end
		if (!rstn)
		begin
			nxt_sync1 = '0;
			nxt_sync2 = '0;
			nxt_sync3 = '0;
			nxt_filt  = '0;
		end
	end

	always_ff @(posedge clk)
	begin
		sync1_ff <= nxt_sync1;
		sync2_ff <= nxt_sync2;
		sync3_ff <= nxt_sync3;
		filt_ff  <= nxt_filt;
	end

	// ------------------------------------------------------------
	// Edge detection
	// ------------------------------------------------------------
	logic prev_sclk_ff;
	logic nxt_prev_sclk;
	logic sclk_rise;

	always_comb
	begin
		nxt_prev_sclk = prev_sclk_ff;
		if (ce)
			nxt_prev_sclk = filt_ff.serial_clk;
		if (!rstn)
			nxt_prev_sclk = 1'b0;
	end

	always_ff @(posedge clk)
	begin
		prev_sclk_ff <= nxt_prev_sclk;
	end

	assign sclk_rise = filt_ff.serial_clk & ~prev_sclk_ff;

	// ------------------------------------------------------------
	// Power-up timer and state
	// ------------------------------------------------------------
	attn_state_t            state_ff;
	attn_state_t            nxt_state;
	logic [`ATTN_CNT_W-1:0] cnt_ff;
	logic [`ATTN_CNT_W-1:0] nxt_cnt;
	logic                   timer_done;

	assign timer_done = (cnt_ff == POWERUP_CYCLES[`ATTN_CNT_W-1:0]
	                    - `ATTN_CNT_ONE);

	always_comb
	begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		if (ce)
		begin
			case (state_ff)
				ATTN_ST_WAIT:
				begin
					if (timer_done)
						nxt_state = ATTN_ST_RUN;
					else
						nxt_cnt = cnt_ff + `ATTN_CNT_ONE;
				end
				ATTN_ST_RUN:
				begin
					nxt_state = ATTN_ST_RUN;
				end
				default:
				begin
					nxt_state = ATTN_ST_WAIT;
					nxt_cnt   = `ATTN_CNT_ZERO;
				end
			endcase
		end
		if (!rstn)
		begin
			nxt_state = ATTN_ST_WAIT;
			nxt_cnt   = `ATTN_CNT_ZERO;
		end
	end

	always_ff @(posedge clk)
	begin
		state_ff <= nxt_state;
		cnt_ff   <= nxt_cnt;
	end

	// ------------------------------------------------------------
	// Power-up word selection
	// ------------------------------------------------------------
	logic [`ATTN_WORD_MSB:0] pup_word;

	always_comb
	begin
		if (filt_ff.load_strobe)
			pup_word = filt_ff.parallel_control_word;
		else
		begin
			case ({filt_ff.powerup_select_b, filt_ff.powerup_select_a})
				2'b00:   pup_word = `ATTN_PUP_MAX;
				2'b01:   pup_word = `ATTN_PUP_24DB;
				2'b10:   pup_word = `ATTN_PUP_16DB;
				2'b11:   pup_word = `ATTN_PUP_MIN;
				default: pup_word = `ATTN_PUP_MIN;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Serial shift register
	// ------------------------------------------------------------
	// The shift register keeps running through the power-up wait so
	// a cascaded part downstream still sees its data.
	logic [`ATTN_WORD_MSB:0] shift_ff;
	logic [`ATTN_WORD_MSB:0] nxt_shift;
	logic                    shift_en;

	assign shift_en = filt_ff.interface_select
	                & ~filt_ff.load_strobe
	                & sclk_rise;

	always_comb
	begin
		nxt_shift = shift_ff;
		if (ce && shift_en)
			nxt_shift = {shift_ff[`ATTN_WORD_MSB-1:0],
			             filt_ff.serial_data_in};
		if (!rstn)
			nxt_shift = '0;
	end

	always_ff @(posedge clk)
	begin
		shift_ff <= nxt_shift;
	end

	// ------------------------------------------------------------
	// Attenuation state
	// ------------------------------------------------------------
	logic [`ATTN_WORD_MSB:0] word_ff;
	logic [`ATTN_WORD_MSB:0] nxt_word;
	logic                    done_ff;
	logic                    nxt_done;

	always_comb
	begin
		nxt_word = word_ff;
		nxt_done = done_ff;
		if (ce)
		begin
			if (state_ff == ATTN_ST_WAIT)
			begin
				if (timer_done)
				begin
					nxt_word = pup_word;
					nxt_done = 1'b1;
				end
			end
			else if (filt_ff.load_strobe)
			begin
				if (filt_ff.interface_select)
					nxt_word = shift_ff;
				else
					nxt_word = filt_ff.parallel_control_word;
			end
		end
		if (!rstn)
		begin
			nxt_word = `ATTN_RESET_WORD;
			nxt_done = 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		word_ff <= nxt_word;
		done_ff <= nxt_done;
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// Each low bit adds its binary weight of half-dB steps, so the
	// total loss in half-dB units is simply the inverted word.
	logic [`ATTN_WORD_MSB:0] half_db_ff;
	logic [`ATTN_WORD_MSB:0] nxt_half_db;

	always_comb
	begin
		nxt_half_db = ~nxt_word;
	end

	always_ff @(posedge clk)
	begin
		half_db_ff <= nxt_half_db;
	end

	assign atten_word      = word_ff;
	assign atten_half_db   = half_db_ff;
	assign serial_data_out = shift_ff[`ATTN_WORD_MSB];
	assign powerup_done    = done_ff;

endmodule

`default_nettype wire

// ### attn_chk.sv
// Port checker for the attenuator step control block
`timescale 1ns/1ps
`default_nettype none
module attn_chk #(
	parameter int POWERUP_CYCLES = 50
) (
	input wire logic                 clk,             // Clock
	input wire logic                 rstn,            // Reset, low
	input wire logic                 ce,              // Clock enable
	input wire attn_pkg::attn_pins_t pins,            // Raw pins
	input wire logic [5:0]           atten_word,      // State
	input wire logic [5:0]           atten_half_db,   // Loss
	input wire logic                 serial_data_out, // Cascade out
	input wire logic                 powerup_done     // Start-up latched
);
	import attn_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn || !ce);
	// Start-up state from the two select pins
	function automatic logic [5:0] pup(input logic a, input logic b);
		return {a & b, b, {4{a | b}}};
	endfunction
	// Windows of 8 cover the pin filter delay plus one update
	half_db_a: assert property (atten_half_db == ~atten_word)
		else $error("loss not inverse of state");
	hold_low_a: assert property (
		(powerup_done && !pins.load_strobe)[*8] |=> $stable(atten_word))
		else $error("state moved with strobe low");
	done_sticky_a: assert property (powerup_done |=> powerup_done)
		else $error("start-up flag dropped");
	wait_idle_a: assert property (!powerup_done |-> atten_word == 6'h3F)
		else $error("state changed before start-up latch");
	pup_pins_a: assert property ($rose(powerup_done) && !pins.load_strobe |->
		atten_word == pup(pins.powerup_select_a, pins.powerup_select_b))
		else $error("wrong start-up state from select pins");
	pup_word_a: assert property ($rose(powerup_done) && pins.load_strobe |->
		atten_word == pins.parallel_control_word)
		else $error("wrong start-up state from parallel word");
	direct_par_a: assert property ((powerup_done && pins.load_strobe &&
		!pins.interface_select && $stable(pins.parallel_control_word))[*8]
		|=> atten_word == $past(pins.parallel_control_word))
		else $error("state not following parallel word");
	sel_mask_a: assert property ((!pins.interface_select)[*8] |=>
		$stable(serial_data_out))
		else $error("shift moved with serial interface off");
	strobe_mask_a: assert property (pins.load_strobe[*8] |=>
		$stable(serial_data_out))
		else $error("shift moved with strobe high");
	cover property ($rose(powerup_done));
	cover property ($rose(serial_data_out));
	cover property (powerup_done && $fell(pins.load_strobe));
endmodule
bind attn_step_control attn_chk #(.POWERUP_CYCLES(POWERUP_CYCLES)) u_chk (
	.clk(clk), .rstn(rstn), .ce(ce), .pins(pins), .atten_word(atten_word),
	.atten_half_db(atten_half_db), .serial_data_out(serial_data_out),
	.powerup_done(powerup_done));
`default_nettype wire

// ### attn_host.sv
// Host controller model driving the attenuator control pins
`timescale 1ns/1ps
`default_nettype none
module attn_host (
	input  wire logic                 clk,  // System clock
	output var  attn_pkg::attn_pins_t pins  // Control pins
);
	import attn_pkg::*;
	initial pins = '0;
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Serial clock runs only inside a frame, 10 clocks per half
	task automatic send(input logic [5:0] w);
		for (int i = 5; i >= 0; i--)
		begin
			pins.serial_data_in <= w[i];
			tick(10);
			pins.serial_clk <= 1'b1;
			tick(10);
			pins.serial_clk <= 1'b0;
		end
		// Released data line shows the inverse, never a held value
		pins.serial_data_in <= ~w[0];
		tick(10);
	endtask
	task automatic pulse();
		pins.load_strobe <= 1'b1;
		tick(8);
		pins.load_strobe <= 1'b0;
		tick(8);
	endtask
	task automatic set(input logic [1:0] ab, input logic sel, input logic le,
		input logic [5:0] w);
		pins.powerup_select_a <= ab[0];
		pins.powerup_select_b <= ab[1];
		pins.interface_select <= sel;
		pins.load_strobe <= le;
		pins.parallel_control_word <= w;
		tick(8);
	endtask
endmodule
`default_nettype wire

// ### testbench.sv
// Self-checking bench for the attenuator step control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import attn_pkg::*;
	logic       clk = 1'b0;
	logic       rstn = 1'b0;
	attn_pins_t pins;
	logic [5:0] word;
	logic [5:0] half;
	logic       sdo;
	logic       done;
	logic       ce = 1'b1;
	int         err_count = 0;
	int         checked = 0;
	logic [5:0] pw [5] = '{6'h00, 6'h0F, 6'h1F, 6'h3F, 6'h2D};
	logic [5:0] sw [2] = '{6'h2A, 6'h15};
	always #4 clk = ~clk;
	attn_host host (.clk(clk), .pins(pins));
	attn_step_control #(.POWERUP_CYCLES(50)) DUT (.clk(clk), .rstn(rstn), .ce(ce),
		.pins(pins), .atten_word(word), .atten_half_db(half),
		.serial_data_out(sdo), .powerup_done(done));
	task automatic cmp(input string what, input logic [5:0] exp, input logic [5:0] got);
		checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_state(input logic [5:0] w);
		cmp("atten_word", w, word);
		cmp("atten_half_db", ~w, half);
	endtask
	task automatic stop_test();
		$display("Comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Select stays low so a held strobe after start-up keeps the parallel word
	task automatic boot(input logic [1:0] ab, input logic le);
		int n = 0;
		host.set(ab, 1'b0, le, 6'h2D);
		rstn <= 1'b0;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		repeat (45) @(posedge clk);
		cmp("powerup_done", 6'h00, {5'h00, done});
		while (done !== 1'b1 && n < 20)
		begin
			@(posedge clk);
			n++;
		end
		cmp("powerup_done", 6'h01, {5'h00, done});
	endtask
	initial
	begin
		@(posedge clk);
		for (int k = 0; k < 5; k++)
		begin
			boot(k[1:0], k == 4);
			chk_state(pw[k]);
		end
		host.set(2'h0, 1'b0, 1'b0, 6'h3F);
		host.set(2'h0, 1'b1, 1'b0, 6'h3F);
		for (int i = 0; i < 2; i++)
		begin
			host.send(sw[i]);
			chk_state(i ? sw[0] : 6'h2D);
			cmp("serial_data_out", {5'h00, sw[i][5]}, {5'h00, sdo});
			host.pulse();
			chk_state(sw[i]);
		end
		host.set(2'h0, 1'b1, 1'b1, 6'h3F);
		host.send(6'h33);
		host.set(2'h0, 1'b1, 1'b0, 6'h3F);
		host.pulse();
		chk_state(6'h15);
		host.set(2'h0, 1'b0, 1'b0, 6'h36);
		host.send(6'h0C);
		chk_state(6'h15);
		host.pulse();
		chk_state(6'h36);
		host.set(2'h0, 1'b1, 1'b0, 6'h36);
		host.pulse();
		chk_state(6'h15);
		host.set(2'h0, 1'b0, 1'b1, 6'h3E);
		chk_state(6'h3E);
		host.set(2'h0, 1'b0, 1'b1, 6'h1B);
		chk_state(6'h1B);
		// Clock enable low must freeze even the direct parallel path
		ce <= 1'b0;
		host.set(2'h0, 1'b0, 1'b1, 6'h3E);
		chk_state(6'h1B);
		ce <= 1'b1;
		repeat (8) @(posedge clk);
		chk_state(6'h3E);
		stop_test();
	end
	// The sequence needs about 1,000 clocks; this cuts a hang well after
	initial
	begin
		#100000;
		err_count++;
		stop_test();
	end
endmodule
`default_nettype wire
